/* hdl/ofdbs_top.sv */
// ofdbs_top: output driver format decode plus two-bank integer and
// fractional dividers with glitchless bank switching, behind APB.
// assumes pclk also clocks the dividers; the frequency select pin is synchronised here.
//
// Operation
// - format 0 off, 1 CMOS true pin, 2 CMOS complement pin, 3 dual CMOS.
// - formats 4..7 are LVDS: normal 2.5/3.3, normal 1.8, fast 2.5/3.3, fast 1.8.
// - formats 8..11 HCSL 50/42.5 ohm ext/int termination, 12 LVPECL.
// - skew is unsigned steps of 35 ps, capped at 280 ps.
// - stopped output driven low-z when bit is 0, high-z when 1.
// - dual CMOS polarity bit 1 inverts the complement pin.
// - edge rate 00 fastest, 01 slow, 10 slower, 11 slowest.
// - drive strength bit 0 gives 50 ohm, 1 gives 25 ohm.
// - integer and fractional dividers each hold sets A and B.
// - with set B in use the output divides by the set B value.
// - an output fed from set A can be moved to set B.
// - integer bank bit picks A at 0, B at 1, live at run time.
// - fractional bank bit switches between two complete sets.
// - only spread enables and integer sets may change while their bank is selected.
// - frequency select pin can switch banks like the register bits.
// - once select is asserted, set B values set the output frequency.
// - fractional set holds 128x ratio floor, residue numerator, denominator.
// - bank switches produce no runt pulses or glitches.
`timescale 1ns/1ps
module ofdbs_top import ofdbs_pkg::*; (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// frequency select pin
	input wire logic frequency_select_pin,
	// output pins
	output logic out_true,
	output logic out_true_oe_n,
	output logic out_comp,
	output logic out_comp_oe_n,
	// analog driver controls
	output logic mode_cmos_true,
	output logic mode_cmos_comp,
	output logic mode_lvds,
	output logic mode_hcsl,
	output logic mode_pecl,
	output logic lvds_fast,
	output logic supply_1v8,
	output logic hcsl_int_term,
	output logic hcsl_42ohm,
	output logic complement_polarity,
	output logic [SKEW_W-1:0] output_delay_steps,
	output logic [1:0] single_ended_edge_rate,
	output logic single_ended_drive_strength,
	// divider status
	output logic spread_on,
	output logic int_bank_active,
	output logic frac_bank_active
);
	typedef struct packed {
		logic [DRV_W-1:0] drv;
		logic [INT_W-1:0] int_a;
		logic [INT_W-1:0] int_b;
		logic [INTG_W-1:0] fa_intg;
		logic [RES_W-1:0] fa_res;
		logic [RES_W-1:0] fa_den;
		logic [INTG_W-1:0] fb_intg;
		logic [RES_W-1:0] fb_res;
		logic [RES_W-1:0] fb_den;
		logic [BANK_W-1:0] bank;
		logic pin_s1;
		logic pin_s2;
		logic int_bank;
		logic frac_bank;
		logic [INT_W-1:0] int_cur;
		logic [INT_W-1:0] int_cnt;
		logic [PER_W-1:0] frac_len;
		logic [PER_W-1:0] frac_cnt;
		logic [RES_W-1:0] frac_acc;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic o_true;
		logic o_true_oe_n;
		logic o_comp;
		logic o_comp_oe_n;
		logic m_cmos_t;
		logic m_cmos_c;
		logic m_lvds;
		logic m_hcsl;
		logic m_pecl;
		logic m_fast;
		logic m_1v8;
		logic m_int_term;
		logic m_42;
		logic m_inv;
		logic [SKEW_W-1:0] m_skew;
		logic [1:0] m_slew;
		logic m_str;
		logic m_spread;
	} ofdbs_state_s;

	ofdbs_state_s q;
	ofdbs_state_s n;

	logic setup;
	logic access;
	logic sel_int;
	logic sel_frac;
	logic int_wrap;
	logic frac_wrap;
	logic [INT_W-1:0] int_eff;
	logic int_clk;
	logic frac_clk;
	logic [FMT_W-1:0] fmt;
	logic hit;
	logic frac_lock;
	logic [31:0] rd;
	logic src_clk;
	logic [PER_W-1:0] per;
	logic [RES_W:0] acc_sum;
	logic [INTG_W-1:0] new_intg;
	logic [RES_W-1:0] new_res;
	logic [RES_W-1:0] new_den;
	logic is_diff;
	logic drv_t;
	logic drv_c;

	always_comb begin
		n = q;
		setup = psel && !penable;
		access = psel && penable && q.pready;
		// register bit or pin may ask for bank B; the pin only via its synchroniser
		sel_int = q.bank[INT_SEL_BIT] || (q.bank[PIN_EN_BIT] && q.pin_s2);
		sel_frac = q.bank[FRAC_SEL_BIT] || (q.bank[PIN_EN_BIT] && q.pin_s2);
		n.pin_s1 = frequency_select_pin;
		n.pin_s2 = q.pin_s1;
		// fractional set registers are locked while that set is live or requested
		frac_lock = 1'b0;
		if (paddr == OFS_FA_INTG || paddr == OFS_FA_RES || paddr == OFS_FA_DEN) begin
			frac_lock = !q.frac_bank || !sel_frac;
		end else if (paddr == OFS_FB_INTG || paddr == OFS_FB_RES || paddr == OFS_FB_DEN) begin
			frac_lock = q.frac_bank || sel_frac;
		end
		// read decode
		hit = 1'b1;
		rd = 32'h0000_0000;
		if (paddr == OFS_DRV) begin
			rd[DRV_W-1:0] = q.drv;
		end else if (paddr == OFS_INT_A) begin
			rd[INT_W-1:0] = q.int_a;
		end else if (paddr == OFS_INT_B) begin
			rd[INT_W-1:0] = q.int_b;
		end else if (paddr == OFS_FA_INTG) begin
			rd[INTG_W-1:0] = q.fa_intg;
		end else if (paddr == OFS_FA_RES) begin
			rd[RES_W-1:0] = q.fa_res;
		end else if (paddr == OFS_FA_DEN) begin
			rd[RES_W-1:0] = q.fa_den;
		end else if (paddr == OFS_FB_INTG) begin
			rd[INTG_W-1:0] = q.fb_intg;
		end else if (paddr == OFS_FB_RES) begin
			rd[RES_W-1:0] = q.fb_res;
		end else if (paddr == OFS_FB_DEN) begin
			rd[RES_W-1:0] = q.fb_den;
		end else if (paddr == OFS_BANK) begin
			rd[BANK_W-1:0] = q.bank;
		end else if (paddr == OFS_STAT) begin
			rd[4:0] = {q.o_true, q.pin_s2, q.frac_bank, q.int_bank, 1'b0};
		end else begin
			hit = 1'b0;
		end
		// zero-wait answer: result is registered in setup, pready high in access
		n.pready = setup;
		if (setup) begin
			n.prdata = pwrite ? 32'h0000_0000 : rd;
			n.pslverr = !hit || (pwrite && (paddr == OFS_STAT || frac_lock));
		end
		if (access && pwrite && !q.pslverr) begin
			if (paddr == OFS_DRV) begin
				n.drv = pwdata[DRV_W-1:0];
			end else if (paddr == OFS_INT_A) begin
				n.int_a = pwdata[INT_W-1:0];
			end else if (paddr == OFS_INT_B) begin
				n.int_b = pwdata[INT_W-1:0];
			end else if (paddr == OFS_FA_INTG) begin
				n.fa_intg = pwdata[INTG_W-1:0];
			end else if (paddr == OFS_FA_RES) begin
				n.fa_res = pwdata[RES_W-1:0];
			end else if (paddr == OFS_FA_DEN) begin
				n.fa_den = pwdata[RES_W-1:0];
			end else if (paddr == OFS_FB_INTG) begin
				n.fb_intg = pwdata[INTG_W-1:0];
			end else if (paddr == OFS_FB_RES) begin
				n.fb_res = pwdata[RES_W-1:0];
			end else if (paddr == OFS_FB_DEN) begin
				n.fb_den = pwdata[RES_W-1:0];
			end else if (paddr == OFS_BANK) begin
				n.bank = pwdata[BANK_W-1:0];
			end
		end
		// integer divider: ratio and bank only reload at the wrap, so no runt cycle
		int_eff = (q.int_cur < INT_MIN) ? INT_MIN : q.int_cur;
		int_wrap = q.int_cnt >= int_eff - INT_W'(1);
		int_clk = q.int_cnt < (int_eff >> 1);
		if (int_wrap) begin
			n.int_cnt = '0;
			n.int_bank = sel_int;
			n.int_cur = sel_int ? q.int_b : q.int_a;
		end else begin
			n.int_cnt = q.int_cnt + INT_W'(1);
		end
		// fractional divider: whole cycles from the 128x integer part,
		// residue over denominator adds one cycle on carry
		frac_wrap = q.frac_cnt >= q.frac_len - PER_W'(1);
		frac_clk = q.frac_cnt < (q.frac_len >> 1);
		new_intg = sel_frac ? q.fb_intg : q.fa_intg;
		new_res = sel_frac ? q.fb_res : q.fa_res;
		new_den = sel_frac ? q.fb_den : q.fa_den;
		per = {1'b0, new_intg[INTG_W-1:FRAC_SHIFT]};
		acc_sum = {1'b0, q.frac_acc} + {1'b0, new_res};
		if (frac_wrap) begin
			n.frac_cnt = '0;
			n.frac_bank = sel_frac;
			if (new_den != '0 && acc_sum >= {1'b0, new_den}) begin
				n.frac_acc = RES_W'(acc_sum - {1'b0, new_den});
				per = per + PER_W'(1);
			end else begin
				n.frac_acc = (new_den == '0) ? '0 : acc_sum[RES_W-1:0];
			end
			n.frac_len = (per < PER_MIN) ? PER_MIN : per;
		end else begin
			n.frac_cnt = q.frac_cnt + PER_W'(1);
		end
		// spread enables follow software live, even on the active set
		n.m_spread = q.frac_bank ? q.bank[SS_B_BIT] : q.bank[SS_A_BIT];
		// driver decode; reserved codes leave every mode off
		fmt = q.drv[FMT_LSB +: FMT_W];
		n.m_cmos_t = fmt == FMT_CMOS_T || fmt == FMT_CMOS_D;
		n.m_cmos_c = fmt == FMT_CMOS_C || fmt == FMT_CMOS_D;
		n.m_lvds = fmt >= FMT_LVDS_LO && fmt <= FMT_LVDS_HI;
		n.m_fast = n.m_lvds && fmt[1];
		n.m_1v8 = n.m_lvds && fmt[0];
		n.m_hcsl = fmt >= FMT_HCSL_LO && fmt <= FMT_HCSL_HI;
		n.m_int_term = n.m_hcsl && fmt[0];
		n.m_42 = n.m_hcsl && fmt[1];
		n.m_pecl = fmt == FMT_PECL;
		n.m_inv = fmt == FMT_CMOS_D && q.drv[INV_BIT];
		n.m_skew = (q.drv[SKEW_LSB +: SKEW_W] > MAX_STEPS) ? MAX_STEPS
			: q.drv[SKEW_LSB +: SKEW_W];
		n.m_slew = q.drv[SLEW_LSB +: 2];
		n.m_str = q.drv[STR_BIT];
		// pins
		is_diff = n.m_lvds || n.m_hcsl || n.m_pecl;
		drv_t = n.m_cmos_t || is_diff;
		drv_c = n.m_cmos_c || is_diff;
		src_clk = q.drv[SRC_BIT] ? frac_clk : int_clk;
		if (q.drv[STOP_BIT]) begin
			n.o_true = 1'b0;
			n.o_comp = 1'b0;
			n.o_true_oe_n = !drv_t || q.drv[HIGHZ_BIT];
			n.o_comp_oe_n = !drv_c || q.drv[HIGHZ_BIT];
		end else begin
			n.o_true = drv_t && src_clk;
			n.o_comp = drv_c && ((is_diff || n.m_inv) ? !src_clk : src_clk);
			n.o_true_oe_n = !drv_t;
			n.o_comp_oe_n = !drv_c;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.drv <= DRV_RST;
			q.int_a <= INT_RST;
			q.int_b <= INT_RST;
			q.int_cur <= INT_RST;
			q.fa_intg <= INTG_RST;
			q.fb_intg <= INTG_RST;
			q.fa_res <= RES_RST;
			q.fb_res <= RES_RST;
			q.fa_den <= DEN_RST;
			q.fb_den <= DEN_RST;
			q.bank <= BANK_RST;
			q.frac_len <= PER_MIN;
			q.o_true_oe_n <= 1'b1;
			q.o_comp_oe_n <= 1'b1;
		end else if (ce) begin
			q <= n;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign out_true = q.o_true;
	assign out_true_oe_n = q.o_true_oe_n;
	assign out_comp = q.o_comp;
	assign out_comp_oe_n = q.o_comp_oe_n;
	assign mode_cmos_true = q.m_cmos_t;
	assign mode_cmos_comp = q.m_cmos_c;
	assign mode_lvds = q.m_lvds;
	assign mode_hcsl = q.m_hcsl;
	assign mode_pecl = q.m_pecl;
	assign lvds_fast = q.m_fast;
	assign supply_1v8 = q.m_1v8;
	assign hcsl_int_term = q.m_int_term;
	assign hcsl_42ohm = q.m_42;
	assign complement_polarity = q.m_inv;
	assign output_delay_steps = q.m_skew;
	assign single_ended_edge_rate = q.m_slew;
	assign single_ended_drive_strength = q.m_str;
	assign spread_on = q.m_spread;
	assign int_bank_active = q.int_bank;
	assign frac_bank_active = q.frac_bank;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence apb_wr_s;
		psel && !penable && pwrite && ce ##1 psel && penable && pready && ce;
	endsequence

	sequence pin_req_s;
		ce && q.bank[PIN_EN_BIT] && q.pin_s2;
	endsequence

	fmt_dual_a: assert property (ce && fmt == FMT_CMOS_D |=> mode_cmos_true
		&& mode_cmos_comp && !mode_lvds) else $error("dual cmos decode wrong");
	fmt_lvds_a: assert property (ce && fmt[3:2] == 2'b01 |=> mode_lvds
		&& lvds_fast == $past(fmt[1]) && supply_1v8 == $past(fmt[0]))
		else $error("lvds decode wrong");
	fmt_hcsl_a: assert property (ce && fmt[3:2] == 2'b10 |=> mode_hcsl
		&& hcsl_42ohm == $past(fmt[1]) && hcsl_int_term == $past(fmt[0]) && !mode_pecl)
		else $error("hcsl decode wrong");
	fmt_reserved_a: assert property (ce && fmt > FMT_PECL |=> !mode_cmos_true
		&& !mode_cmos_comp && !mode_lvds && !mode_hcsl && !mode_pecl
		&& out_true_oe_n && out_comp_oe_n) else $error("reserved format enabled a driver");
	skew_cap_a: assert property (ce |=> output_delay_steps <= MAX_STEPS)
		else $error("skew above cap");
	stop_state_a: assert property (ce && q.drv[STOP_BIT] && fmt == FMT_CMOS_D |=>
		!out_true && (out_true_oe_n == $past(q.drv[HIGHZ_BIT])))
		else $error("stopped state drive wrong");
	dual_pol_a: assert property (ce && fmt == FMT_CMOS_D && !q.drv[STOP_BIT] |=>
		(out_comp == (out_true ^ $past(q.drv[INV_BIT]))))
		else $error("dual cmos polarity wrong");
	drive_pass_a: assert property (ce |=>
		single_ended_edge_rate == $past(q.drv[SLEW_LSB +: 2])
		&& single_ended_drive_strength == $past(q.drv[STR_BIT]))
		else $error("edge rate or strength not passed through");
	bank_boundary_a: assert property ($changed(int_bank_active) |-> $past(int_wrap))
		else $error("integer bank moved mid cycle");
	frac_boundary_a: assert property ($changed(frac_bank_active) |-> $past(frac_wrap))
		else $error("fractional bank moved mid cycle");
	ratio_load_a: assert property (ce && int_wrap |=> q.int_cur == ($past(sel_int)
		? $past(q.int_b) : $past(q.int_a))) else $error("ratio not from selected set");
	pin_select_a: assert property (pin_req_s ##0 int_wrap |=> int_bank_active)
		else $error("pin did not select bank b");
	spread_live_a: assert property (ce |=> spread_on == $past(frac_bank_active
		? q.bank[SS_B_BIT] : q.bank[SS_A_BIT])) else $error("spread enable not live");
	frac_guard_a: assert property (apb_wr_s ##0 (paddr == OFS_FA_INTG
		&& $past(frac_lock)) |=> $stable(q.fa_intg)) else $error("live fractional set rewritten");
endmodule : ofdbs_top

/* hdl/ofdbs_pkg.sv */
// ofdbs_pkg: register map, field layout, reset values and format codes
// for the output format and divider bank select block.
// assumes a 32-bit APB slave, byte addresses, one word per register.
package ofdbs_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_DRV = 8'h00;
	localparam logic [7:0] OFS_INT_A = 8'h04;
	localparam logic [7:0] OFS_INT_B = 8'h08;
	localparam logic [7:0] OFS_FA_INTG = 8'h0C;
	localparam logic [7:0] OFS_FA_RES = 8'h10;
	localparam logic [7:0] OFS_FA_DEN = 8'h14;
	localparam logic [7:0] OFS_FB_INTG = 8'h18;
	localparam logic [7:0] OFS_FB_RES = 8'h1C;
	localparam logic [7:0] OFS_FB_DEN = 8'h20;
	localparam logic [7:0] OFS_BANK = 8'h24;
	localparam logic [7:0] OFS_STAT = 8'h28;
	// driver config field layout
	localparam int DRV_W = 15;
	localparam int FMT_LSB = 0;
	localparam int FMT_W = 4;
	localparam int SKEW_LSB = 4;
	localparam int SKEW_W = 4;
	localparam int HIGHZ_BIT = 8;
	localparam int INV_BIT = 9;
	localparam int SLEW_LSB = 10;
	localparam int STR_BIT = 12;
	localparam int STOP_BIT = 13;
	localparam int SRC_BIT = 14;
	// bank control field layout
	localparam int BANK_W = 5;
	localparam int INT_SEL_BIT = 0;
	localparam int FRAC_SEL_BIT = 1;
	localparam int SS_A_BIT = 2;
	localparam int SS_B_BIT = 3;
	localparam int PIN_EN_BIT = 4;
	// divider widths; fractional integer part is 128 times the ratio
	localparam int INT_W = 8;
	localparam int INTG_W = 16;
	localparam int FRAC_SHIFT = 7;
	localparam int RES_W = 15;
	localparam int PER_W = INTG_W - FRAC_SHIFT + 1;
	// reset values
	localparam logic [DRV_W-1:0] DRV_RST = 15'h0000;
	localparam logic [INT_W-1:0] INT_RST = 8'h04;
	localparam logic [INTG_W-1:0] INTG_RST = 16'h0200;
	localparam logic [RES_W-1:0] RES_RST = 15'h0000;
	localparam logic [RES_W-1:0] DEN_RST = 15'h0001;
	localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
	localparam logic [INT_W-1:0] INT_MIN = 8'h02;
	localparam logic [PER_W-1:0] PER_MIN = 10'h002;
	// skew steps
	localparam int STEP_PS = 35;
	localparam int MAX_DELAY_PS = 280;
	localparam logic [SKEW_W-1:0] MAX_STEPS = SKEW_W'(MAX_DELAY_PS / STEP_PS);
	// driver format codes
	localparam logic [FMT_W-1:0] FMT_OFF = 4'h0;
	localparam logic [FMT_W-1:0] FMT_CMOS_T = 4'h1;
	localparam logic [FMT_W-1:0] FMT_CMOS_C = 4'h2;
	localparam logic [FMT_W-1:0] FMT_CMOS_D = 4'h3;
	localparam logic [FMT_W-1:0] FMT_LVDS_LO = 4'h4;
	localparam logic [FMT_W-1:0] FMT_LVDS_HI = 4'h7;
	localparam logic [FMT_W-1:0] FMT_HCSL_LO = 4'h8;
	localparam logic [FMT_W-1:0] FMT_HCSL_HI = 4'hB;
	localparam logic [FMT_W-1:0] FMT_PECL = 4'hC;
endpackage : ofdbs_pkg

/* tb/output_format_and_divider_bank_select_tb_top.sv */
// output_format_and_divider_bank_select_tb_top: self-checking bench for ofdbs_top.
// assumes the apb slave answers with no wait states and the dividers run on pclk.
`timescale 1ns/1ps
module output_format_and_divider_bank_select_tb_top;
	import ofdbs_pkg::*;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, sel_pin = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, out_true, out_true_oe_n, out_comp, out_comp_oe_n;
	logic m_ct, m_cc, m_lvds, m_hcsl, m_pecl, lv_fast, s1v8, h_int, h_42, pol, strn, spr, ib, fb;
	logic [SKEW_W-1:0] dly;
	logic [1:0] edge_rate;
	int n_fail = 0, checks = 0, run = 2, p;
	logic glitch_on = 0, last = 0;
	logic [3:0] skew_tab [4] = '{4'h0, 4'h3, 4'h8, 4'hF};

	always #12.5 pclk = ~pclk;

	ofdbs_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frequency_select_pin(sel_pin), .out_true(out_true),
		.out_true_oe_n(out_true_oe_n), .out_comp(out_comp), .out_comp_oe_n(out_comp_oe_n),
		.mode_cmos_true(m_ct), .mode_cmos_comp(m_cc), .mode_lvds(m_lvds), .mode_hcsl(m_hcsl),
		.mode_pecl(m_pecl), .lvds_fast(lv_fast), .supply_1v8(s1v8), .hcsl_int_term(h_int),
		.hcsl_42ohm(h_42), .complement_polarity(pol), .output_delay_steps(dly),
		.single_ended_edge_rate(edge_rate), .single_ended_drive_strength(strn),
		.spread_on(spr), .int_bank_active(ib), .frac_bank_active(fb));

	task summarize;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %0h got %0h", nm, e, g);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen high at an edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16)
			chk("pready", 1, pready);
		r = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : xfer

	task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] r;
		logic e;
		xfer(1'b1, a, d, r, e);
		chk("write_err", ee, e);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] ed, input logic ee);
		logic [31:0] r;
		logic e;
		xfer(1'b0, a, 32'h0, r, e);
		chk("read_err", ee, e);
		chk("read_data", ed, r);
	endtask : rd

	task wt(input bit f, input logic v);
		int n;
		n = 0;
		while ((f ? fb : ib) !== v && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk(f ? "frac_bank" : "int_bank", v, f ? fb : ib);
	endtask : wt

	// period of out_true in pclk cycles, rising edge to rising edge;
	// the first rise may start a clipped high phase, so it is skipped
	task measure(output int per);
		logic prev;
		int n;
		prev = out_true; per = 0; n = 0;
		while (n < 3 && per < 200) begin
			@(posedge pclk);
			per++;
			if (!prev && out_true === 1'b1) begin
				n++;
				if (n == 2)
					per = 0;
			end
			prev = out_true;
		end
	endtask : measure

	// a half period shorter than the smallest programmed one is a runt
	always @(posedge pclk) begin
		if (glitch_on && out_true !== last) begin
			checks++;
			if (run < 2) begin
				n_fail++;
				$display("unexpected half_period exp 2 got %0d", run);
			end
			run = 1;
		end else
			run = run + 1;
		last = out_true;
	end

	initial begin
		#(25ns * 20000);
		n_fail++;
		summarize();
	end

	initial begin
		logic [4:0] em;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_DRV, 32'h0, 0);
		rd(OFS_INT_A, 32'h4, 0);
		rd(OFS_INT_B, 32'h4, 0);
		rd(OFS_FA_INTG, 32'h200, 0);
		rd(OFS_FB_DEN, 32'h1, 0);
		rd(OFS_BANK, 32'h0, 0);
		for (int c = 0; c < 16; c++) begin
			wr(OFS_DRV, 32'(c), 0);
			repeat (3) @(posedge pclk);
			em = c == 1 ? 5'h10 : c == 2 ? 5'h08 : c == 3 ? 5'h18 : c < 4 ? 5'h00 :
				c < 8 ? 5'h04 : c < 12 ? 5'h02 : c == 12 ? 5'h01 : 5'h00;
			chk("mode", em, {m_ct, m_cc, m_lvds, m_hcsl, m_pecl});
			if (c >= 4 && c < 8)
				chk("lvds_variant", c[1:0], {lv_fast, s1v8});
			if (c >= 8 && c < 12)
				chk("hcsl_variant", c[1:0], {h_42, h_int});
			if (c == 0 || c > 12)
				chk("oe_n", 2'b11, {out_true_oe_n, out_comp_oe_n});
		end
		for (int i = 0; i < 4; i++) begin
			wr(OFS_DRV, 32'h3 | (skew_tab[i] << 4) | (i << 10) | ((i & 1) << 12) | ((i & 1) << 9), 0);
			repeat (3) @(posedge pclk);
			chk("delay_steps", skew_tab[i] > 8 ? 8 : skew_tab[i], dly);
			chk("edge_rate", i, edge_rate);
			chk("strength", i & 1, strn);
			chk("polarity", i & 1, pol);
			repeat (3) begin
				@(negedge pclk);
				chk("comp_pin", out_true ^ (i & 1), out_comp);
			end
		end
		wr(OFS_DRV, 32'h2003, 0);
		repeat (3) @(posedge pclk);
		chk("stop_lowz", 3'b000, {out_true_oe_n, out_comp_oe_n, out_true});
		wr(OFS_DRV, 32'h2103, 0);
		repeat (3) @(posedge pclk);
		chk("stop_highz", 2'b11, {out_true_oe_n, out_comp_oe_n});
		wr(OFS_STAT, 32'h1, 1);
		rd(8'h2C, 32'h0, 1);
		wr(OFS_DRV, 32'h1, 0);
		measure(p);
		chk("int_a_period", 4, p);
		wr(OFS_INT_B, 32'h6, 0);
		glitch_on = 1;
		wr(OFS_BANK, 32'h1, 0);
		wt(0, 1);
		measure(p);
		chk("int_b_period", 6, p);
		// a source change is not a bank switch and may clip one half period
		glitch_on = 0;
		wr(OFS_DRV, 32'h4001, 0);
		wr(OFS_FA_INTG, 32'h100, 1);
		rd(OFS_FA_INTG, 32'h200, 0);
		wr(OFS_FB_INTG, 32'h400, 0);
		wr(OFS_FB_RES, 32'h0, 0);
		measure(p);
		chk("frac_staged_period", 4, p);
		glitch_on = 1;
		wr(OFS_BANK, 32'h3, 0);
		wt(1, 1);
		measure(p);
		chk("frac_b_period", 8, p);
		wr(OFS_FB_INTG, 32'h300, 1);
		wr(OFS_FA_INTG, 32'h300, 0);
		wr(OFS_BANK, 32'h5, 0);
		wt(1, 0);
		measure(p);
		chk("frac_a_period", 6, p);
		repeat (3) @(posedge pclk);
		chk("spread_a", 1, spr);
		wr(OFS_BANK, 32'h9, 0);
		repeat (3) @(posedge pclk);
		chk("spread_off", 0, spr);
		wr(OFS_BANK, 32'h10, 0);
		wt(0, 0);
		@(posedge pclk);
		sel_pin <= 1'b1;
		wt(0, 1);
		wt(1, 1);
		measure(p);
		chk("fs_period", 8, p);
		@(posedge pclk);
		sel_pin <= 1'b0;
		wt(0, 0);
		wt(1, 0);
		glitch_on = 0;
		// clock enable low must freeze out_true, out_true_oe_n, both bank flags and spread_on
		@(posedge pclk);
		ce <= 1'b0;
		repeat (2) @(posedge pclk);
		em = {out_true, ib, fb, out_true_oe_n, spr};
		repeat (5) @(posedge pclk);
		chk("frozen", em, {out_true, ib, fb, out_true_oe_n, spr});
		ce <= 1'b1;
		summarize();
	end
endmodule : output_format_and_divider_bank_select_tb_top
